// >>> rgt_pcm_src.sv
// PCM receive port partner: sends one word MSB first on a bit clock
`timescale 1ns/1ns

module rgt_pcm_src (
	// System clock
	input  wire logic clk,
	// PCM pins
	output logic      pcm_clk,
	output logic      pcm_sync,
	output logic      pcm_data
);
	// ==================================================
	// Sender
	initial begin
		pcm_clk  = 1'b0;
		pcm_sync = 1'b0;
		pcm_data = 1'b0;
	end

	// Bit clock stands still between frames; high halves of four clocks and low halves of five exceed the sync minimum
	task automatic send(input logic [14:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge clk);
			pcm_data = w[i];
			pcm_sync = (i == n - 1);
			repeat (4) @(negedge clk);
			pcm_clk = 1'b1;
			repeat (4) @(negedge clk);
			pcm_clk = 1'b0;
		end
		pcm_sync = 1'b0;
		pcm_data = ~pcm_data;
	endtask
endmodule // rgt_pcm_src

// >>> rgt_pkg.sv
// Constants for the receive gain, sidetone, volume and tone control block
package rgt_pkg;

	// ==================================================
	// Register offsets
	localparam logic [7:0] RGT_PWR_OFS   = 8'h00;
	localparam logic [7:0] RGT_MODE_OFS  = 8'h01;
	localparam logic [7:0] RGT_TXST_OFS  = 8'h02;
	localparam logic [7:0] RGT_RXVOL_OFS = 8'h03;
	localparam logic [7:0] RGT_HIGH_OFS  = 8'h04;
	localparam logic [7:0] RGT_LOW_OFS   = 8'h05;

	// ==================================================
	// Values after reset
	localparam logic [7:0] RGT_PWR_RST   = 8'h00;
	localparam logic [7:0] RGT_MODE_RST  = 8'h00;
	localparam logic [7:0] RGT_TXST_RST  = 8'h40;
	localparam logic [7:0] RGT_RXVOL_RST = 8'h70;
	localparam logic [7:0] RGT_TONE_RST  = 8'h00;

	// ==================================================
	// Field positions
	localparam int RGT_SIDE_MUTE_BIT = 7;
	localparam int RGT_EAR_MUTE_BIT  = 3;
	localparam int RGT_TONE_EN_BIT   = 6;
	localparam int RGT_LINEAR_N_BIT  = 4;
	localparam int RGT_BUZZ_EN_BIT   = 3;

	// ==================================================
	// Code limits
	localparam logic [3:0] RGT_RX_CODE_MAX   = 4'hc;
	localparam logic [2:0] RGT_SIDE_CODE_MAX = 3'h6;
	localparam logic [3:0] RGT_VOL_CODE_MAX  = 4'h9;
	localparam logic [3:0] RGT_RX_TOP_DB     = 4'h6;
	localparam logic [5:0] RGT_SIDE_TOP_DB   = 6'h34;

	// ==================================================
	// PCM word lengths
	localparam logic [3:0] RGT_COMP_LEN = 4'h8;
	localparam logic [3:0] RGT_LIN_LEN  = 4'hf;

	// ==================================================
	// Timing
	localparam int RGT_CLK_NS      = 10;
	localparam int RGT_SAMPLE_NS   = 125000;
	localparam int RGT_SAMPLE_CYC  = RGT_SAMPLE_NS / RGT_CLK_NS;
	localparam int RGT_PHASE_W     = 10;
	localparam logic [9:0] RGT_TRI_MID = 10'h100;

endpackage

// >>> rgt_rx_gain_tone_control.sv
// Receive gain, sidetone, volume, PCM receive order and tone generator control
// Operation
// - Receive gain code 0 gives +6 dB, each step -1 dB, code 12 gives -6 dB.
// - Receive gain resets to code 0111, -1 dB.
// - Sidetone code 0 gives -12 dB, each step -2 dB, code 6 gives -24 dB.
// - Power control bit 7 mutes sidetone regardless of its code.
// - Sidetone code resets to 000, -12 dB.
// - Earphone volume code 0 gives 0 dB, each step -2 dB, code 9 gives -18 dB.
// - Earphone volume resets to code 0000, 0 dB.
// - Power control bit 3 mutes the earphone output.
// - Companded receive word is eight bits, MSB first.
// - Linear receive word is fifteen bits, MSB first.
// - Two 8-bit tone code registers: high at 04, low at 05.
// - High tone register output is 2 dB louder than the low one.
// - 255 single tone codes; code zero gives no tone.
// - High and low tone outputs are summed into one dual tone.
// - Tone generator also drives the pulse density buzzer output.
// - Register 03 holds receive gain in 7:4 and volume in 3:0.
// - Register 02 holds sidetone code in bits 2:0.
`timescale 1ns/1ns

module rgt_rx_gain_tone_control import rgt_pkg::*; #(
	parameter int SAMPLE_CYC = RGT_SAMPLE_CYC
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// Decoded control port
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	output logic      [7:0]         reg_rdata,
	// PCM receive pins
	input  wire logic               pcm_clk,
	input  wire logic               pcm_sync,
	input  wire logic               pcm_data,
	// Received words
	output logic      [7:0]         companded_rx_word,
	output logic      [14:0]        linear_rx_word,
	output logic                    rx_word_valid,
	// Gain settings
	output logic signed [3:0]       rx_gain_db,
	output logic signed [5:0]       side_gain_db,
	output logic                    side_mute,
	output logic signed [5:0]       ear_volume_db,
	output logic                    ear_mute,
	// Tone and buzzer
	output logic signed [7:0]       tone_sum,
	output logic                    buzzer_pdm_out
);

	// ==================================================
	// Registers
	logic [7:0] pwr_reg, mode_reg, txst_reg, rxvol_reg, high_reg, low_reg;
	logic [7:0] rdata_reg, rdata_next;
	wire        wr_pwr   = reg_wr && (reg_addr == RGT_PWR_OFS);
	wire        wr_mode  = reg_wr && (reg_addr == RGT_MODE_OFS);
	wire        wr_txst  = reg_wr && (reg_addr == RGT_TXST_OFS);
	wire        wr_rxvol = reg_wr && (reg_addr == RGT_RXVOL_OFS);
	wire        wr_high  = reg_wr && (reg_addr == RGT_HIGH_OFS);
	wire        wr_low   = reg_wr && (reg_addr == RGT_LOW_OFS);

	always_comb begin
		case (reg_addr)
			RGT_PWR_OFS:   rdata_next = pwr_reg;
			RGT_MODE_OFS:  rdata_next = mode_reg;
			RGT_TXST_OFS:  rdata_next = txst_reg;
			RGT_RXVOL_OFS: rdata_next = rxvol_reg;
			RGT_HIGH_OFS:  rdata_next = high_reg;
			RGT_LOW_OFS:   rdata_next = low_reg;
			default:       rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_reg   <= RGT_PWR_RST;
			mode_reg  <= RGT_MODE_RST;
			txst_reg  <= RGT_TXST_RST;
			rxvol_reg <= RGT_RXVOL_RST;
			high_reg  <= RGT_TONE_RST;
			low_reg   <= RGT_TONE_RST;
			rdata_reg <= 8'h00;
		end else begin
			if (wr_pwr)   pwr_reg   <= reg_wdata;
			if (wr_mode)  mode_reg  <= reg_wdata;
			if (wr_txst)  txst_reg  <= reg_wdata;
			if (wr_rxvol) rxvol_reg <= reg_wdata;
			if (wr_high)  high_reg  <= reg_wdata;
			if (wr_low)   low_reg   <= reg_wdata;
			if (reg_rd)   rdata_reg <= rdata_next;
		end
	end
	assign reg_rdata = rdata_reg;

	// ==================================================
	// Gain decode
	// Reserved codes clamp to the lowest defined step rather than wrapping
	wire [3:0] rx_code   = rxvol_reg[7:4];
	wire [2:0] side_code = txst_reg[2:0];
	wire [3:0] vol_code  = rxvol_reg[3:0];
	wire [3:0] rx_eff    = (rx_code > RGT_RX_CODE_MAX) ? RGT_RX_CODE_MAX : rx_code;
	wire [2:0] side_eff  = (side_code > RGT_SIDE_CODE_MAX) ? RGT_SIDE_CODE_MAX : side_code;
	wire [3:0] vol_eff   = (vol_code > RGT_VOL_CODE_MAX) ? RGT_VOL_CODE_MAX : vol_code;
	wire [3:0] rx_db_next   = 4'(RGT_RX_TOP_DB - rx_eff);
	wire [5:0] side_db_next = 6'(RGT_SIDE_TOP_DB - {2'b00, side_eff, 1'b0});
	wire [5:0] vol_db_next  = 6'(6'h00 - {1'b0, vol_eff, 1'b0});
	logic [3:0] rx_db_reg;
	logic [5:0] side_db_reg, vol_db_reg;
	logic       side_mute_reg, ear_mute_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_db_reg     <= 4'(RGT_RX_TOP_DB - RGT_RXVOL_RST[7:4]);
			side_db_reg   <= RGT_SIDE_TOP_DB;
			vol_db_reg    <= 6'(6'h00 - {1'b0, RGT_RXVOL_RST[3:0], 1'b0});
			side_mute_reg <= 1'b0;
			ear_mute_reg  <= 1'b0;
		end else begin
			rx_db_reg     <= rx_db_next;
			side_db_reg   <= side_db_next;
			vol_db_reg    <= vol_db_next;
			side_mute_reg <= pwr_reg[RGT_SIDE_MUTE_BIT];
			ear_mute_reg  <= pwr_reg[RGT_EAR_MUTE_BIT];
		end
	end
	assign rx_gain_db    = rx_db_reg;
	assign side_gain_db  = side_db_reg;
	assign ear_volume_db = vol_db_reg;
	assign side_mute     = side_mute_reg;
	assign ear_mute      = ear_mute_reg;

	// ==================================================
	// PCM receive
	// A frame cut short keeps the receiver busy, so the next sync is taken as data
	logic [2:0] pin_q1, pin_q2;
	logic       pclk_prev;
	logic       busy_reg;
	logic [3:0] bit_cnt_reg;
	logic [14:0] shift_reg;
	logic [7:0] comp_reg;
	logic [14:0] lin_reg;
	logic       valid_reg;
	wire        pclk_rise = pin_q2[0] && !pclk_prev;
	wire        linear    = !mode_reg[RGT_LINEAR_N_BIT];
	wire [3:0]  word_len  = linear ? RGT_LIN_LEN : RGT_COMP_LEN;
	wire [14:0] shift_next = {shift_reg[13:0], pin_q2[2]};
	wire        start_bit = pclk_rise && !busy_reg && pin_q2[1];
	wire        more_bit  = pclk_rise && busy_reg;
	wire [3:0]  cnt_next  = 4'(bit_cnt_reg + 4'h1);
	wire        word_done = more_bit && (cnt_next == word_len);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q1      <= 3'h0;
			pin_q2      <= 3'h0;
			pclk_prev   <= 1'b0;
			busy_reg    <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 15'h0000;
			comp_reg    <= 8'h00;
			lin_reg     <= 15'h0000;
			valid_reg   <= 1'b0;
		end else begin
			pin_q1    <= {pcm_data, pcm_sync, pcm_clk};
			pin_q2    <= pin_q1;
			pclk_prev <= pin_q2[0];
			valid_reg <= word_done;
			if (start_bit || more_bit) begin
				shift_reg   <= shift_next;
				bit_cnt_reg <= start_bit ? 4'h1 : cnt_next;
			end
			if (start_bit)
				busy_reg <= 1'b1;
			else if (word_done)
				busy_reg <= 1'b0;
			if (word_done && linear)
				lin_reg <= shift_next;
			if (word_done && !linear)
				comp_reg <= shift_next[7:0];
		end
	end
	assign companded_rx_word = comp_reg;
	assign linear_rx_word    = lin_reg;
	assign rx_word_valid     = valid_reg;

	// ==================================================
	// Tone generator
	// Triangle shape instead of a sine table keeps area small at some harmonic cost
	localparam int CW = $clog2(SAMPLE_CYC);
	logic [CW-1:0] smp_cnt_reg;
	wire  smp_tick = (smp_cnt_reg == CW'(SAMPLE_CYC - 1));
	wire  tone_en  = mode_reg[RGT_TONE_EN_BIT];
	wire  [7:0] tone_code [2];
	logic signed [7:0] tone_amp [2];
	assign tone_code[0] = high_reg;
	assign tone_code[1] = low_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			smp_cnt_reg <= '0;
		else
			smp_cnt_reg <= smp_tick ? '0 : CW'(smp_cnt_reg + 1'b1);
	end

	for (genvar i = 0; i < 2; i++) begin : g_tone
		logic [RGT_PHASE_W-1:0] phase_reg;
		wire  [8:0]  ramp = phase_reg[8:0] ^ {9{phase_reg[9]}};
		wire  signed [9:0]  tri_val = $signed(10'({1'b0, ramp}) - RGT_TRI_MID);
		wire  signed [12:0] hi_scaled = 13'(tri_val * 13'sd5) >>> 5;
		wire  signed [9:0]  lo_scaled = tri_val >>> 3;
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				phase_reg <= '0;
			else if (tone_code[i] == 8'h00)
				phase_reg <= '0;
			else if (smp_tick)
				phase_reg <= RGT_PHASE_W'(phase_reg + {2'b00, tone_code[i]});
		end
		assign tone_amp[i] = (tone_code[i] == 8'h00) ? 8'sh00 :
			(i == 0) ? 8'(hi_scaled) : 8'(lo_scaled);
	end

	wire signed [7:0] sum_next = tone_en ? 8'(tone_amp[0] + tone_amp[1]) : 8'sh00;
	logic signed [7:0] sum_reg;
	logic [7:0] pdm_acc_reg;
	logic       pdm_reg;
	wire  [8:0] pdm_sum  = {1'b0, pdm_acc_reg} + {1'b0, sum_reg[7] ^ 1'b1, sum_reg[6:0]};
	wire        buzz_en  = mode_reg[RGT_BUZZ_EN_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_reg     <= 8'sh00;
			pdm_acc_reg <= 8'h00;
			pdm_reg     <= 1'b0;
		end else begin
			sum_reg     <= sum_next;
			pdm_acc_reg <= pdm_sum[7:0];
			pdm_reg     <= buzz_en && pdm_sum[8];
		end
	end
	assign tone_sum       = sum_reg;
	assign buzzer_pdm_out = pdm_reg;

	// ==================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	rx_gain_map_a: assert property (rx_code <= RGT_RX_CODE_MAX |=> rx_gain_db == 4'(6 - $past(rx_code)))
		else $error("receive gain mismatch");
	rx_reserved_a: assert property (rx_code > RGT_RX_CODE_MAX |=> rx_gain_db == -4'sd6)
		else $error("reserved receive code not clamped");
	side_gain_map_a: assert property (side_code <= RGT_SIDE_CODE_MAX
		|=> side_gain_db == 6'(-12 - 2 * $past(side_code)))
		else $error("sidetone gain mismatch");
	side_mute_a: assert property (pwr_reg[RGT_SIDE_MUTE_BIT] |=> side_mute)
		else $error("sidetone not muted");
	ear_vol_map_a: assert property (vol_code <= RGT_VOL_CODE_MAX |=> ear_volume_db == 6'(-2 * $past(vol_code)))
		else $error("volume mismatch");
	ear_mute_a: assert property (pwr_reg[RGT_EAR_MUTE_BIT] |=> ear_mute)
		else $error("earphone not muted");
	high_write_a: assert property (wr_high |=> high_reg == $past(reg_wdata))
		else $error("high tone write lost");
	tone_off_a: assert property ((!tone_en || (high_reg == 8'h00 && low_reg == 8'h00)) |=> tone_sum == 8'sh00)
		else $error("tone present while off");
	buzz_off_a: assert property (!buzz_en |=> !buzzer_pdm_out)
		else $error("buzzer active while disabled");
	word_pulse_a: assert property (rx_word_valid |=> !rx_word_valid)
		else $error("word valid longer than one cycle");

	// ==================================================
	// Read-back, reserved code, unmute, low tone write and range checks
	side_reserved_a: assert property (side_code > RGT_SIDE_CODE_MAX |=> side_gain_db == -6'sd24)
		else $error("reserved sidetone code not clamped");
	vol_reserved_a: assert property (vol_code > RGT_VOL_CODE_MAX |=> ear_volume_db == -6'sd18)
		else $error("reserved volume code not clamped");
	side_unmute_a: assert property (!pwr_reg[RGT_SIDE_MUTE_BIT] |=> !side_mute)
		else $error("sidetone muted while enabled");
	ear_unmute_a: assert property (!pwr_reg[RGT_EAR_MUTE_BIT] |=> !ear_mute)
		else $error("earphone muted while enabled");
	low_write_a: assert property (wr_low |=> low_reg == $past(reg_wdata))
		else $error("low tone write lost");
	tone_read_a: assert property (reg_rd && reg_addr == RGT_HIGH_OFS |=> reg_rdata == $past(high_reg))
		else $error("high tone read mismatch");
	rxvol_read_a: assert property (reg_rd && reg_addr == RGT_RXVOL_OFS |=> reg_rdata == $past(rxvol_reg))
		else $error("receive volume read mismatch");
	txst_read_a: assert property (reg_rd && reg_addr == RGT_TXST_OFS |=> reg_rdata == $past(txst_reg))
		else $error("sidetone register read mismatch");
	tone_span_a: assert property (tone_sum <= 8'sd70 && tone_sum >= -8'sd72)
		else $error("summed tone out of range");

	comp_word_c: cover property (rx_word_valid && !linear);
	lin_word_c: cover property (rx_word_valid && linear);
	dual_tone_c: cover property (tone_en && high_reg != 8'h00 && low_reg != 8'h00 ##1 buzzer_pdm_out);
	both_mute_c: cover property (side_mute && ear_mute);

endmodule // rgt_rx_gain_tone_control

// >>> tb_rx_gain_tone_control.sv
// Self-checking bench for the gain, mute, tone and PCM receive block
`timescale 1ns/1ns

module tb_rx_gain_tone_control;
	import rgt_pkg::*;
	logic               clk, rst_n, reg_wr, reg_rd, pcm_clk, pcm_sync, pcm_data;
	logic               rx_word_valid, side_mute, ear_mute, buzzer_pdm_out;
	logic [7:0]         reg_addr, reg_wdata, reg_rdata, companded_rx_word, d;
	logic [14:0]        linear_rx_word, w;
	logic signed [3:0]  rx_gain_db;
	logic signed [5:0]  side_gain_db, ear_volume_db;
	logic signed [7:0]  tone_sum;
	int                 n_fail, compares, mx, ones, v, hp;
	int                 exp_q[$];

	rgt_rx_gain_tone_control #(.SAMPLE_CYC(8)) uut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.pcm_clk(pcm_clk), .pcm_sync(pcm_sync), .pcm_data(pcm_data),
		.companded_rx_word(companded_rx_word), .linear_rx_word(linear_rx_word),
		.rx_word_valid(rx_word_valid), .rx_gain_db(rx_gain_db), .side_gain_db(side_gain_db),
		.side_mute(side_mute), .ear_volume_db(ear_volume_db), .ear_mute(ear_mute),
		.tone_sum(tone_sum), .buzzer_pdm_out(buzzer_pdm_out));
	rgt_pcm_src pm (.clk(clk), .pcm_clk(pcm_clk), .pcm_sync(pcm_sync), .pcm_data(pcm_data));

	// ==================================================
	// Reference model: settings from the code tables, words in send order
	function automatic int rx_db_model(input int c);
		return (c > 12) ? -6 : 6 - c;
	endfunction

	function automatic int side_db_model(input int c);
		return (c > 6) ? -24 : -12 - 2 * c;
	endfunction

	function automatic int vol_db_model(input int c);
		return (c > 9) ? -18 : -2 * c;
	endfunction

	// ==================================================
	// Tasks
	task automatic chk(input string n, input int e, input logic signed [15:0] g);
		compares++;
		if (g !== 16'(e)) begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk);
		reg_wr    = 1'b1;
		reg_addr  = a;
		reg_wdata = x;
		@(negedge clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_rd   = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rdata", e, reg_rdata);
	endtask

	// Peak magnitude of the tone and count of buzzer ones over a window
	task automatic meas;
		mx   = 0;
		ones = 0;
		repeat (9000) begin
			@(negedge clk);
			v = tone_sum;
			if (v < 0) v = -v;
			if (v > mx) mx = v;
			ones += buzzer_pdm_out;
		end
	endtask

	task automatic pcm(input int n);
		int k;
		w = 15'($urandom);
		exp_q.push_back((n == 8) ? int'(w[7:0]) : int'(w));
		fork
			pm.send(w, n);
			begin
				for (k = 0; k < 300 && rx_word_valid !== 1'b1; k++) @(negedge clk);
				chk("rx_word_valid", 1, k < 300);
			end
		join
	endtask

	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==================================================
	// Clock, watchdog, tests
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Tests take about half a millisecond
	initial begin
		#700000;
		n_fail++;
		print_verdict;
	end

	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, rst_n, n_fail, compares} = '0;
		v = $urandom(23);
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("rx_gain_db", -1, rx_gain_db);
		chk("side_gain_db", -12, side_gain_db);
		chk("ear_volume_db", 0, ear_volume_db);
		rdchk(RGT_TXST_OFS, 8'h40);
		rdchk(RGT_RXVOL_OFS, 8'h70);
		rdchk(RGT_HIGH_OFS, 8'h00);
		rdchk(RGT_LOW_OFS, 8'h00);
		rdchk(8'h3c, 8'h00);
		$display("Test reset done");
		for (int c = 0; c < 16; c++) begin
			d = {c[3:0], 4'(15 - c)};
			wr(RGT_RXVOL_OFS, d);
			chk("rx_gain_db", rx_db_model(c), rx_gain_db);
			chk("ear_volume_db", vol_db_model(15 - c), ear_volume_db);
			rdchk(RGT_RXVOL_OFS, d);
		end
		for (int c = 0; c < 8; c++) begin
			d = (8'($urandom) & 8'hf8) | 8'(c);
			wr(RGT_TXST_OFS, d);
			chk("side_gain_db", side_db_model(c), side_gain_db);
		end
		for (int c = 0; c < 4; c++) begin
			wr(RGT_PWR_OFS, {c[1], 3'h0, c[0], 3'h0});
			chk("side_mute", c[1], side_mute);
			chk("ear_mute", c[0], ear_mute);
			rdchk(RGT_PWR_OFS, {c[1], 3'h0, c[0], 3'h0});
		end
		wr(RGT_PWR_OFS, 8'h00);
		$display("Test gains done");
		wr(RGT_MODE_OFS, 8'h48);
		meas;
		chk("silent_peak", 0, mx);
		wr(RGT_HIGH_OFS, 8'($rtoi(1209.0 / 7.8125 + 0.5)));
		meas;
		chk("high_peak", 1, mx > 31 && mx <= 40);
		hp = mx;
		wr(RGT_HIGH_OFS, 8'h00);
		wr(RGT_LOW_OFS, 8'($rtoi(697.0 / 7.8125 + 0.5)));
		meas;
		chk("low_peak", 1, mx > 0 && mx <= 32);
		chk("peak_ratio", 1, hp > mx);
		wr(RGT_HIGH_OFS, 8'($rtoi(1209.0 / 7.8125 + 0.5)));
		meas;
		chk("dual_peak", 1, mx > 40);
		chk("buzzer_mix", 1, ones > 0 && ones < 9000);
		wr(RGT_MODE_OFS, 8'h40);
		meas;
		chk("buzzer_off", 0, ones);
		$display("Test tone done");
		wr(RGT_MODE_OFS, 8'h10);
		pcm(8);
		chk("companded_rx_word", exp_q.pop_front(), companded_rx_word);
		wr(RGT_MODE_OFS, 8'h00);
		pcm(15);
		chk("linear_rx_word", exp_q.pop_front(), linear_rx_word);
		$display("Test pcm done");
		print_verdict;
	end
endmodule // tb_rx_gain_tone_control
